/* File: verilog/eba_block_master.sv */
`timescale 1ns/1ps
module eba_block_master (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // configuration
  input wire logic [1:0] BLOCK_BYTES,
  input wire logic [3:0] CAPACITY_SEL,
  // requests
  input wire logic WRITE_BLOCK_REQUEST,
  input wire logic READ_BLOCK_REQUEST,
  input wire logic RELEASE_BUS_REQUEST,
  input wire logic CLOCK_PULSE_REQUEST,
  input wire logic [15:0] BLOCK_NUMBER,
  input wire logic [127:0] WRITE_DATA,
  // results
  output logic [7:0] STATUS,
  output logic [15:0] BLOCK_COUNT,
  output logic [127:0] READ_DATA,
  // bus pins, open drain
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE
);
  // ****************
  // declarations
  // ****************
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic [6:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic tick, end_q, byte_end, bus_free, last_byte, in_range, rx, drive;
  eba_pkg::eba_state_t state_r;
  eba_pkg::eba_step_t step_r;
  logic [7:0] status_r, fin_r;
  logic poll_r, rd_r, rel_r, nack_r;
  logic [3:0] pulses_r, cnt_r, cap_r;
  logic [11:0] wait_r;
  logic [15:0] addr_r, count_r;
  logic [1:0] bsel_r;
  logic [7:0] shift_r, tx_byte, cur_byte;
  logic [127:0] wdata_r, rdata_r;
  logic [16:0] blocks;
  logic scl_oe_r, sda_oe_r;

  // ****************
  // functions
  // ****************
  function automatic logic [2:0] blk_log(input logic [1:0] sel);
    case (sel)
      2'h0: blk_log = eba_pkg::BLOCK_LOG_MIN;
      2'h1: blk_log = eba_pkg::BLOCK_LOG_MIN + 3'h1;
      default: blk_log = eba_pkg::BLOCK_LOG_MIN + 3'h2;
    endcase
  endfunction : blk_log

  function automatic logic [16:0] blk_total(input logic [3:0] cap, input logic [1:0] sel);
    blk_total = (eba_pkg::CAP_MIN_BYTES << cap) >> blk_log(sel);
  endfunction : blk_total

  // small parts carry the upper address bits in the slave byte
  function automatic logic [7:0] sla_byte(input logic [15:0] a, input logic [3:0] cap,
                                          input logic rd);
    logic [2:0] m;
    m = 3'h0;
    if (cap <= eba_pkg::CAP_SHORT_ADDR_MAX) begin
      m = 3'((4'h1 << cap) - 4'h1);
    end
    sla_byte = eba_pkg::SLAVE_BASE | {4'h0, a[10:8] & m, rd};
  endfunction : sla_byte

  // ****************
  // pin synchronisers
  // ****************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= SCL_IN;
      scl_s_r <= scl_m_r;
      sda_m_r <= SDA_IN;
      sda_s_r <= sda_m_r;
    end
  end

  // ****************
  // decode
  // ****************
  assign blocks = blk_total(CAPACITY_SEL, BLOCK_BYTES);
  assign in_range = (CAPACITY_SEL <= eba_pkg::CAP_MAX)
                    && ({1'b0, BLOCK_NUMBER} < blocks);
  assign bus_free = scl_s_r & sda_s_r;
  assign tick = (div_r == eba_pkg::QTR_LAST);
  assign end_q = tick && (q_r == 2'h3);
  assign byte_end = (state_r == eba_pkg::ST_BYTE) && end_q && (bit_r == eba_pkg::ACK_BIT);
  assign last_byte = (cnt_r == 4'((5'h1 << blk_log(bsel_r)) - 5'h1));
  assign rx = (step_r == eba_pkg::SP_DATA_RX);

  always_comb begin
    case (step_r)
      eba_pkg::SP_SLA_W, eba_pkg::SP_POLL: tx_byte = sla_byte(addr_r, cap_r, 1'b0);
      eba_pkg::SP_SLA_R: tx_byte = sla_byte(addr_r, cap_r, 1'b1);
      eba_pkg::SP_ADDR_HI: tx_byte = addr_r[15:8];
      eba_pkg::SP_ADDR_LO: tx_byte = addr_r[7:0];
      eba_pkg::SP_DATA_TX: tx_byte = wdata_r[{cnt_r, 3'h0} +: 8];
      default: tx_byte = 8'hFF;
    endcase
  end

  assign cur_byte = (bit_r == 4'h0) ? tx_byte : shift_r;
  // on the acknowledge bit a receiver holds data low except after the last byte
  assign drive = (bit_r == eba_pkg::ACK_BIT) ? (rx && !last_byte) : (!rx && !cur_byte[7]);

  // ****************
  // quarter-bit timing
  // ****************
  always_ff @(posedge CLK_SYS) begin
    if (RESET || state_r == eba_pkg::ST_IDLE || state_r == eba_pkg::ST_WAIT) begin
      div_r <= 7'h00;
      q_r <= 2'h0;
    end else if (tick) begin
      div_r <= 7'h00;
      q_r <= q_r + 2'h1;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end

  // ****************
  // shifter and buffers
  // ****************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      nack_r <= 1'b0;
      rdata_r <= '0;
    end else if (state_r != eba_pkg::ST_BYTE) begin
      bit_r <= 4'h0;
    end else if (tick) begin
      case (q_r)
        2'h0: shift_r <= cur_byte;
        2'h2: begin
          if (bit_r == eba_pkg::ACK_BIT) begin
            nack_r <= sda_s_r;
          end else if (rx) begin
            shift_r <= {shift_r[6:0], sda_s_r};
          end
        end
        2'h3: begin
          if (bit_r == eba_pkg::ACK_BIT) begin
            bit_r <= 4'h0;
            if (rx) begin
              rdata_r[{cnt_r, 3'h0} +: 8] <= shift_r;
            end
          end else begin
            bit_r <= bit_r + 4'h1;
            if (!rx) begin
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ****************
  // line drivers
  // ****************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (tick) begin
      case (state_r)
        eba_pkg::ST_START: begin
          case (q_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            default: scl_oe_r <= 1'b1;
          endcase
        end
        eba_pkg::ST_BYTE: begin
          case (q_r)
            2'h0: sda_oe_r <= drive;
            2'h1: scl_oe_r <= 1'b0;
            2'h3: scl_oe_r <= 1'b1;
            default: ;
          endcase
        end
        eba_pkg::ST_STOP: begin
          case (q_r)
            2'h0: scl_oe_r <= 1'b1;
            2'h1: sda_oe_r <= 1'b1;
            2'h2: scl_oe_r <= 1'b0;
            default: sda_oe_r <= 1'b0;
          endcase
        end
        eba_pkg::ST_PULSE: begin
          case (q_r)
            2'h0: begin
              scl_oe_r <= 1'b1;
              sda_oe_r <= 1'b0;
            end
            2'h2: scl_oe_r <= 1'b0;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // ****************
  // sequencer
  // ****************
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_r <= eba_pkg::ST_IDLE;
      step_r <= eba_pkg::SP_SLA_W;
      status_r <= eba_pkg::STATUS_RST;
      fin_r <= eba_pkg::OK_CODE;
      poll_r <= 1'b0;
      rd_r <= 1'b0;
      rel_r <= 1'b0;
      pulses_r <= 4'h0;
      wait_r <= 12'h000;
      addr_r <= 16'h0000;
      cap_r <= 4'h0;
      bsel_r <= 2'h0;
      cnt_r <= 4'h0;
      wdata_r <= '0;
    end else begin
      case (state_r)
        eba_pkg::ST_IDLE: begin
          if (WRITE_BLOCK_REQUEST || READ_BLOCK_REQUEST) begin
            if (!in_range) begin
              status_r <= eba_pkg::PARAM_ERROR_CODE;
            end else if (!bus_free) begin
              status_r <= eba_pkg::BUS_ERROR_CODE;
            end else begin
              rd_r <= !WRITE_BLOCK_REQUEST;
              status_r <= WRITE_BLOCK_REQUEST ? eba_pkg::TRANSMIT_CODE
                                              : eba_pkg::RECEIVE_CODE;
              addr_r <= 16'(BLOCK_NUMBER << blk_log(BLOCK_BYTES));
              cap_r <= CAPACITY_SEL;
              bsel_r <= BLOCK_BYTES;
              cnt_r <= 4'h0;
              wdata_r <= WRITE_DATA;
              step_r <= eba_pkg::SP_SLA_W;
              poll_r <= 1'b0;
              fin_r <= eba_pkg::OK_CODE;
              state_r <= eba_pkg::ST_START;
            end
          end else if (RELEASE_BUS_REQUEST || CLOCK_PULSE_REQUEST) begin
            rel_r <= RELEASE_BUS_REQUEST;
            pulses_r <= 4'h0;
            status_r <= eba_pkg::TRANSMIT_CODE;
            state_r <= eba_pkg::ST_PULSE;
          end
        end
        eba_pkg::ST_START: begin
          if (end_q) begin
            state_r <= eba_pkg::ST_BYTE;
          end
        end
        eba_pkg::ST_BYTE: begin
          if (byte_end) begin
            case (step_r)
              eba_pkg::SP_SLA_W, eba_pkg::SP_SLA_R: begin
                if (nack_r) begin
                  fin_r <= eba_pkg::ADDRESS_NACK_CODE;
                  state_r <= eba_pkg::ST_STOP;
                end else if (step_r == eba_pkg::SP_SLA_R) begin
                  step_r <= eba_pkg::SP_DATA_RX;
                end else if (cap_r > eba_pkg::CAP_SHORT_ADDR_MAX) begin
                  step_r <= eba_pkg::SP_ADDR_HI;
                end else begin
                  step_r <= eba_pkg::SP_ADDR_LO;
                end
              end
              eba_pkg::SP_ADDR_HI, eba_pkg::SP_ADDR_LO, eba_pkg::SP_DATA_TX: begin
                if (nack_r) begin
                  fin_r <= eba_pkg::DATA_NACK_CODE;
                  state_r <= eba_pkg::ST_STOP;
                end else if (step_r == eba_pkg::SP_ADDR_HI) begin
                  step_r <= eba_pkg::SP_ADDR_LO;
                end else if (step_r == eba_pkg::SP_ADDR_LO) begin
                  step_r <= rd_r ? eba_pkg::SP_SLA_R : eba_pkg::SP_DATA_TX;
                  state_r <= rd_r ? eba_pkg::ST_START : eba_pkg::ST_BYTE;
                end else if (last_byte) begin
                  poll_r <= 1'b1;
                  status_r <= eba_pkg::WRITE_CYCLE_STATE;
                  state_r <= eba_pkg::ST_STOP;
                end else begin
                  cnt_r <= cnt_r + 4'h1;
                end
              end
              eba_pkg::SP_DATA_RX: begin
                if (last_byte) begin
                  fin_r <= eba_pkg::OK_CODE;
                  state_r <= eba_pkg::ST_STOP;
                end else begin
                  cnt_r <= cnt_r + 4'h1;
                end
              end
              default: begin
                // a busy memory refuses the poll; stop and wait again
                poll_r <= nack_r;
                fin_r <= eba_pkg::OK_CODE;
                state_r <= eba_pkg::ST_STOP;
              end
            endcase
          end
        end
        eba_pkg::ST_STOP: begin
          if (end_q) begin
            if (poll_r) begin
              wait_r <= 12'h000;
              state_r <= eba_pkg::ST_WAIT;
            end else begin
              status_r <= fin_r;
              state_r <= eba_pkg::ST_IDLE;
            end
          end
        end
        eba_pkg::ST_WAIT: begin
          if (wait_r == eba_pkg::POLL_LAST) begin
            step_r <= eba_pkg::SP_POLL;
            state_r <= eba_pkg::ST_START;
          end else begin
            wait_r <= wait_r + 12'h001;
          end
        end
        eba_pkg::ST_PULSE: begin
          if (end_q) begin
            pulses_r <= pulses_r + 4'h1;
            if (!rel_r) begin
              status_r <= eba_pkg::OK_CODE;
              state_r <= eba_pkg::ST_IDLE;
            end else if (sda_s_r) begin
              fin_r <= eba_pkg::OK_CODE;
              state_r <= eba_pkg::ST_STOP;
            end else if (pulses_r + 4'h1 == eba_pkg::MAX_RELEASE_PULSES) begin
              fin_r <= eba_pkg::BUS_ERROR_CODE;
              state_r <= eba_pkg::ST_STOP;
            end
          end
        end
        default: state_r <= eba_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      count_r <= eba_pkg::BLOCK_COUNT_RST;
    end else begin
      count_r <= 16'(blocks);
    end
  end

  // ****************
  // outputs
  // ****************
  assign STATUS = status_r;
  assign BLOCK_COUNT = count_r;
  assign READ_DATA = rdata_r;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = scl_oe_r;
  assign SDA_OE = sda_oe_r;

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_req_bad;
    state_r == eba_pkg::ST_IDLE && (WRITE_BLOCK_REQUEST || READ_BLOCK_REQUEST) && !in_range;
  endsequence
  sequence s_addr_nack;
    byte_end && nack_r && (step_r == eba_pkg::SP_SLA_W || step_r == eba_pkg::SP_SLA_R);
  endsequence
  sequence s_one_pulse;
    state_r == eba_pkg::ST_PULSE && !rel_r && end_q;
  endsequence

  a_param_reject: assert property (s_req_bad |=> (status_r == eba_pkg::PARAM_ERROR_CODE
    && state_r == eba_pkg::ST_IDLE) ##1 (!scl_oe_r && !sda_oe_r))
    else $error("bad block number not rejected");
  a_bus_error: assert property ((state_r == eba_pkg::ST_IDLE && in_range && !bus_free
    && (WRITE_BLOCK_REQUEST || READ_BLOCK_REQUEST)) |=>
    status_r == eba_pkg::BUS_ERROR_CODE && state_r == eba_pkg::ST_IDLE)
    else $error("busy bus not reported");
  a_start_order: assert property ((state_r == eba_pkg::ST_START && $rose(sda_oe_r))
    |-> !scl_oe_r)
    else $error("start edge with clock low");
  a_slave_base: assert property ((state_r == eba_pkg::ST_BYTE && bit_r == 4'h0
    && q_r == 2'h1 && (step_r == eba_pkg::SP_SLA_W || step_r == eba_pkg::SP_POLL))
    |-> shift_r[7:4] == 4'hA && !shift_r[0])
    else $error("slave byte wrong");
  a_addr_nack: assert property (s_addr_nack |=> state_r == eba_pkg::ST_STOP
    && fin_r == eba_pkg::ADDRESS_NACK_CODE)
    else $error("address nack not reported");
  a_data_nack: assert property ((byte_end && nack_r && step_r == eba_pkg::SP_DATA_TX)
    |=> state_r == eba_pkg::ST_STOP && fin_r == eba_pkg::DATA_NACK_CODE)
    else $error("data nack not reported");
  a_write_phase: assert property ((state_r == eba_pkg::ST_WAIT)
    |-> status_r == eba_pkg::WRITE_CYCLE_STATE)
    else $error("write cycle status wrong");
  a_pulse_limit: assert property ((state_r == eba_pkg::ST_PULSE)
    |-> pulses_r < eba_pkg::MAX_RELEASE_PULSES)
    else $error("too many release pulses");
  a_single_pulse: assert property (s_one_pulse |=> state_r == eba_pkg::ST_IDLE
    && status_r == eba_pkg::OK_CODE && !scl_oe_r)
    else $error("single pulse did not end");
  a_stop_edge: assert property (($past(state_r) == eba_pkg::ST_STOP && $fell(sda_oe_r))
    |-> !scl_oe_r)
    else $error("stop edge with clock low");
  a_busy_msb: assert property (status_r[7] == (state_r != eba_pkg::ST_IDLE))
    else $error("busy bit out of step");
  a_poll_gap: assert property ((state_r == eba_pkg::ST_WAIT && wait_r != eba_pkg::POLL_LAST)
    |=> state_r == eba_pkg::ST_WAIT)
    else $error("poll started early");
  a_poll_start: assert property ((state_r == eba_pkg::ST_WAIT && wait_r == eba_pkg::POLL_LAST)
    |=> state_r == eba_pkg::ST_START && step_r == eba_pkg::SP_POLL)
    else $error("poll not started");
endmodule : eba_block_master

/* File: verilog/eba_pkg.sv */
// Operation
// - blocks are 4 bytes by default, selectable as 8 or 16 bytes
// - capacity selector 0 (2K bits) to 8 (512K bits) sets address layout
// - block count equals byte capacity divided by block size
// - a request checks the bus is free, then sends start before addressing
// - slave address byte derives from block number, based on A0h
// - out-of-range block number reports 44h and starts no bus activity
// - bus unusable at request time reports 60h and abandons request
// - missing acknowledge to the address byte reports 20h
// - refused data byte reports 41h
// - status 80h during a write, A0h in write cycle, C0h for a whole read
// - stuck bus is freed by at most 9 dummy clock pulses
// - exactly one clock pulse can be issued on demand
// - transfers end with a stop condition, after errors and completion
// - status top bit set while busy, cleared when finished
// - after writing, poll 100 us after each stop with start and write address
package eba_pkg;
  // ****************
  // timing
  // ****************
  localparam int CLK_HZ = 25000000;
  localparam int SCL_HZ = 100000;
  // rounded up so the bus never runs above its rate
  localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam int POLL_US = 100;
  localparam int POLL_CYC = (CLK_HZ / 1000000) * POLL_US;
  localparam logic [11:0] POLL_LAST = 12'(POLL_CYC - 1);
  // ****************
  // codes and limits
  // ****************
  localparam logic [7:0] SLAVE_BASE = 8'hA0;
  localparam logic [7:0] OK_CODE = 8'h00;
  localparam logic [7:0] PARAM_ERROR_CODE = 8'h44;
  localparam logic [7:0] ADDRESS_NACK_CODE = 8'h20;
  localparam logic [7:0] DATA_NACK_CODE = 8'h41;
  localparam logic [7:0] BUS_ERROR_CODE = 8'h60;
  localparam logic [7:0] TRANSMIT_CODE = 8'h80;
  localparam logic [7:0] WRITE_CYCLE_STATE = TRANSMIT_CODE + 8'h20;
  localparam logic [7:0] RECEIVE_CODE = TRANSMIT_CODE + 8'h40;
  localparam logic [3:0] MAX_RELEASE_PULSES = 4'h9;
  localparam logic [3:0] CAP_MAX = 4'h8;
  localparam logic [3:0] CAP_SHORT_ADDR_MAX = 4'h3;
  localparam logic [16:0] CAP_MIN_BYTES = 17'h00100;
  localparam logic [2:0] BLOCK_LOG_MIN = 3'h2;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] BLOCK_COUNT_RST = 16'h0000;
  // ****************
  // types
  // ****************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_START = 6'h02, ST_BYTE = 6'h04,
    ST_STOP = 6'h08, ST_WAIT = 6'h10, ST_PULSE = 6'h20
  } eba_state_t;
  typedef enum logic [6:0] {
    SP_SLA_W = 7'h01, SP_ADDR_HI = 7'h02, SP_ADDR_LO = 7'h04, SP_DATA_TX = 7'h08,
    SP_SLA_R = 7'h10, SP_DATA_RX = 7'h20, SP_POLL = 7'h40
  } eba_step_t;
endpackage : eba_pkg

/* File: test/eba_eeprom_model.sv */
`timescale 1ns/1ps
// ****************
// serial memory on the far side of the bus
// ****************
module eba_eeprom_model #(
  parameter int BUSY_NS = 250000
) (
  // bus lines, sda_pull high pulls the line low
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  // faults and address mode commanded by the bench
  input wire logic nack_addr,
  input wire logic nack_data,
  input wire logic two_addr
);
  logic [7:0] mem [0:65535];
  logic [7:0] sh, hi, last_sla;
  logic [15:0] ptr;
  logic [2:0] pg;
  logic act, rw, ok, wrote;
  int bc, nb, stops, poll_nacks;
  realtime busy_until;
  initial begin
    sda_pull = 1'b0;
    act = 1'b0;
    wrote = 1'b0;
    stops = 0;
    poll_nacks = 0;
    busy_until = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    bc = 0;
    nb = 0;
  end
  // the internal write starts only at the stop that ends a data write
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    stops++;
    if (wrote) busy_until = $realtime + BUSY_NS;
    wrote = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (bc < 8) sh = {sh[6:0], sda};
    else if (rw && nb > 0 && sda) act = 1'b0;
    bc++;
  end
  // line is let go at every falling clock so a released line reads high
  always @(negedge scl) if (act) begin
    sda_pull = 1'b0;
    if (bc == 9) begin
      bc = 0;
      nb++;
      if (rw && nb > 1) ptr++;
    end
    if (bc == 8) begin
      ok = 1'b1;
      if (nb == 0) begin
        last_sla = sh;
        rw = sh[0];
        ok = sh[7:4] == 4'hA && !nack_addr && $realtime >= busy_until;
        if (!ok && !rw) poll_nacks++;
        if (!rw) pg = sh[3:1];
      end else if (!rw && two_addr && nb == 1) hi = sh;
      else if (!rw && nb == (two_addr ? 2 : 1)) ptr = two_addr ? {hi, sh} : {5'h00, pg, sh};
      else if (!rw) begin
        ok = !nack_data;
        if (ok) begin
          mem[ptr] = sh;
          ptr++;
          wrote = 1'b1;
        end
      end
      // in a read the master owns the acknowledge slot, so the line is left free
      sda_pull = ok && !(rw && nb > 0);
      if (!ok) act = 1'b0;
    end else if (rw && nb > 0) sda_pull = !mem[ptr][7 - bc];
  end
endmodule : eba_eeprom_model

/* File: test/tb_eba_block_master.sv */
`timescale 1ns/1ps
module tb_eba_block_master;
  localparam int TIMEOUT_CYC = 90000;
  logic clk_sys, reset, wr_req, rd_req, rel_req, pulse_req;
  logic [1:0] block_bytes;
  logic [3:0] capacity_sel;
  logic [15:0] block_number, block_count, blk;
  logic [127:0] write_data, read_data;
  logic [7:0] status;
  logic scl_oe, sda_oe, m_pull, tb_sda_pull, nack_addr, nack_data, scl_w, sda_w;
  logic scl_out, sda_out;
  int err_count = 0, n_compared = 0, cyc = 0, act_cnt = 0, falls = 0, seed;
  // wired-and lines with pull-ups
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe | m_pull | tb_sda_pull);
  always #20 clk_sys = ~clk_sys;
  always @(negedge scl_w) falls++;
  always @(posedge clk_sys) begin
    cyc++;
    if (scl_oe | sda_oe) act_cnt++;
    if (cyc == TIMEOUT_CYC) begin
      err_count++;
      finish_test();
    end
  end
  eba_block_master eba_block_master_inst (
    .CLK_SYS(clk_sys), .RESET(reset), .BLOCK_BYTES(block_bytes),
    .CAPACITY_SEL(capacity_sel), .WRITE_BLOCK_REQUEST(wr_req), .READ_BLOCK_REQUEST(rd_req),
    .RELEASE_BUS_REQUEST(rel_req), .CLOCK_PULSE_REQUEST(pulse_req),
    .BLOCK_NUMBER(block_number), .WRITE_DATA(write_data), .STATUS(status),
    .BLOCK_COUNT(block_count), .READ_DATA(read_data), .SCL_IN(scl_w), .SCL_OUT(scl_out),
    .SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe)
  );
  eba_eeprom_model eba_eeprom_model_inst (
    .scl(scl_w), .sda(sda_w), .sda_pull(m_pull), .nack_addr(nack_addr),
    .nack_data(nack_data), .two_addr(capacity_sel >= 4'h4)
  );
  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] exp_count(input logic [3:0] cap, input logic [1:0] bb);
    int bytes;
    bytes = 4 << ((bb > 2'h2) ? 2 : bb);
    return 16'((256 << cap) / bytes);
  endfunction : exp_count
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // kind 0 write, 1 read, 2 release, 3 single pulse; status is settled on return
  task automatic req(input int kind);
    @(negedge clk_sys);
    {pulse_req, rel_req, rd_req, wr_req} = 4'h1 << kind;
    @(negedge clk_sys);
    {pulse_req, rel_req, rd_req, wr_req} = 4'h0;
  endtask : req
  task automatic wait_for(input logic [7:0] mask, input logic [7:0] val);
    while ((status & mask) !== val) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : wait_for
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ****************
  // sequence
  // ****************
  initial begin
    seed = 49;
    clk_sys = 1'b0;
    reset = 1'b1;
    {pulse_req, rel_req, rd_req, wr_req} = 4'h0;
    {tb_sda_pull, nack_addr, nack_data} = 3'h0;
    block_bytes = 2'h0;
    capacity_sel = 4'h7;
    block_number = 16'h0000;
    write_data = 128'h0;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(status, 8'h00);
    // random sizes, block number one or two past the last block
    for (int i = 0; i < 10; i++) begin
      capacity_sel = 4'($unsigned($random(seed)) % 9);
      block_bytes = 2'($random(seed));
      repeat (2) @(negedge clk_sys);
      chk(block_count, exp_count(capacity_sel, block_bytes));
      block_number = exp_count(capacity_sel, block_bytes) + 16'(i & 1);
      act_cnt = 0;
      req(i % 2);
      chk(status, 8'h44);
      repeat (20) @(negedge clk_sys);
      chk(act_cnt, 0);
    end
    capacity_sel = 4'hC;
    req(0);
    chk(status, 8'h44);
    // write then read back a random block of the 32-kbyte part
    capacity_sel = 4'h7;
    block_bytes = 2'h0;
    blk = 16'($unsigned($random(seed)) % 8192);
    block_number = blk;
    write_data = {4{$random(seed)}};
    eba_eeprom_model_inst.stops = 0;
    repeat (2) @(negedge clk_sys);
    req(0);
    chk(status, 8'h80);
    wait_for(8'hFF, 8'hA0);
    chk(status, 8'hA0);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h00);
    for (int k = 0; k < 4; k++) begin
      chk(eba_eeprom_model_inst.mem[16'(blk * 4 + k)], write_data[8*k+:8]);
    end
    chk(eba_eeprom_model_inst.last_sla, 8'hA0);
    // memory busy 250 us: the poll near 190 us is refused, the one near 400 us taken
    chk(eba_eeprom_model_inst.poll_nacks, 1);
    chk(eba_eeprom_model_inst.stops, 3);
    req(1);
    chk(status, 8'hC0);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h00);
    chk(read_data[31:0], write_data[31:0]);
    // slave refuses its address
    nack_addr = 1'b1;
    eba_eeprom_model_inst.stops = 0;
    req(0);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h20);
    chk(eba_eeprom_model_inst.stops, 1);
    nack_addr = 1'b0;
    // write protected, block 300 of 2-kbyte part lands in page 4
    capacity_sel = 4'h3;
    block_number = 16'd300;
    nack_data = 1'b1;
    repeat (2) @(negedge clk_sys);
    req(0);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h41);
    chk(eba_eeprom_model_inst.last_sla, 8'hA8);
    nack_data = 1'b0;
    // data line stuck low
    tb_sda_pull = 1'b1;
    repeat (4) @(negedge clk_sys);
    act_cnt = 0;
    req(0);
    chk(status, 8'h60);
    repeat (20) @(negedge clk_sys);
    chk(act_cnt, 0);
    // the closing stop adds one low clock phase to the pulse count
    falls = 0;
    req(2);
    chk(status, 8'h80);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h60);
    chk(falls, 10);
    tb_sda_pull = 1'b0;
    repeat (4) @(negedge clk_sys);
    falls = 0;
    req(2);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h00);
    chk(falls, 2);
    falls = 0;
    req(3);
    chk(status[7], 1'b1);
    wait_for(8'h80, 8'h00);
    chk(status, 8'h00);
    chk(falls, 1);
    chk({scl_out, sda_out}, 2'h0);
    finish_test();
  end
endmodule : tb_eba_block_master
